//--- hw/mae_map.vh
`ifndef MAE_MAP_VH
`define MAE_MAP_VH
// ==================================================
// timing
`define MAE_CLK_NS 25
`define MAE_TICK_NS 10000000
`define MAE_PWR_WAIT_MS 100
`define MAE_TICK_MS 10
`define MAE_TICKS_PER_S 16'd100
// ==================================================
// wishbone word indices (byte address = index * 4)
`define MAE_OFS_CHAR 3'd0
`define MAE_OFS_STATUS 3'd1
`define MAE_OFS_GC 3'd2
`define MAE_OFS_TX 3'd3
`define MAE_OFS_SCFG_A 3'd4
`define MAE_OFS_SCFG_B 3'd5
// status fields
`define MAE_ST_BUSY 0
`define MAE_ST_RES_LSB 4
`define MAE_ST_HOOK 8
// ==================================================
// modem chip register addresses
`define MAE_MREG_BASE 8'he0
`define MAE_MREG_GC 8'he0
`define MAE_MREG_TX 8'he1
`define MAE_MREG_RX 8'he2
// general control words and bits
`define MAE_GC_RESET_WORD 16'h1180
`define MAE_GC_NORM_WORD 16'h1100
`define MAE_GC_IRQEN_BIT 6
`define MAE_GC_RST_BIT 7
`define MAE_GC_PWR_BIT 8
`define MAE_GC_HOOK_BIT 9
`define MAE_GC_EQU_BIT 10
`define MAE_GC_LOOP_BIT 11
`define MAE_GC_XTAL_BIT 12
// transmit mode word fields
`define MAE_TX_MODE_DTMF 4'h1
`define MAE_TX_LVL_0DB 3'h7
`define MAE_TX_LVL_M10DB5 3'h0
`define MAE_TX_UNUSED 4'h0
`define MAE_TX_DIGIT_ON 1'b1
`define MAE_TX_NO_TONE 16'h1e00
`define MAE_TONE_1209 4'h5
`define MAE_TONE_2100 4'ha
// ==================================================
// configuration register indices and reset values
`define MAE_SIDX_WAIT 8'd6
`define MAE_SIDX_TIMEOUT 8'd7
`define MAE_SIDX_TONE 8'd11
`define MAE_SIDX_EQU 8'd24
`define MAE_SIDX_TXS 8'd25
`define MAE_SIDX_RXS 8'd26
`define MAE_S6_RST 8'd2
`define MAE_S7_RST 8'd50
`define MAE_S11_RST 8'd10
`define MAE_S24_RST 8'd0
`define MAE_S25_RST 16'h1e00
`define MAE_S26_RST 16'h0000
`define MAE_STD_V22BIS 8'd0
`define MAE_X_BLIND 8'd1
// result codes
`define MAE_RES_NONE 2'd0
`define MAE_RES_CONNECT 2'd1
`define MAE_RES_NOCARR 2'd2
// ==================================================
// characters
`define MAE_CH_CR 8'h0d
`define MAE_CH_A 8'h41
`define MAE_CH_T 8'h54
`define MAE_CH_AT 8'h40
`define MAE_CH_R 8'h52
`define MAE_CH_E 8'h45
`define MAE_CH_F 8'h46
`define MAE_CH_B 8'h42
`define MAE_CH_X 8'h58
`define MAE_CH_H 8'h48
`define MAE_CH_S 8'h53
`define MAE_CH_D 8'h44
`define MAE_CH_W 8'h57
`define MAE_CH_EQ 8'h3d
`define MAE_CH_STAR 8'h2a
`define MAE_CH_HASH 8'h23
`define MAE_CH_0 8'h30
`define MAE_CH_9 8'h39
`define MAE_CH_Z 8'h5a
`define MAE_DLY_F2 16'd2
`endif

//--- hw/mae_at_ctrl.v
// How it works
// - standard select zero picks V.22 bis, default
// - calling mode one dials blind, default
// - dial: off-hook, wait wait-register seconds, dial
// - each tone lasts tone-register times 10 ms
// - carrier found reports CONNECT 2400
// - no carrier before timeout reports NO CARRIER
// - equaliser register steers equaliser bit, default off
// - transmitter configured from tx setup before call
// - receiver configured from rx setup before call
// - register write goes to E0 hex plus index
// - power-up writes 1180, waits 100 ms, writes 1100
// - control bits 7 reset, 8 power, 9 hook
// - crystal bit 12, no loopback, irq off
// - hook command one takes line off-hook
// - tx mode 0001 selects DTMF, bits 8-5 unused
// - tx level 111 is 0 dB, 000 -10.5
// - tone codes 0101 1209 Hz, 1010 2100 Hz
`timescale 1ns/1ps
`include "mae_map.vh"

module mae_at_ctrl #(
  parameter TICK_CYCLES = `MAE_TICK_NS / `MAE_CLK_NS
) (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire carrier_detect,
  output reg modem_wr,
  output reg [7:0] modem_addr,
  output reg [15:0] modem_wdata,
  output wire off_hook,
  output reg [1:0] result_code
);

  // ==================================================
  // exec states
  localparam E_PWR1 = 4'd0;
  localparam E_PWRW = 4'd1;
  localparam E_PWR2 = 4'd2;
  localparam E_IDLE = 4'd3;
  localparam E_CFGTX = 4'd4;
  localparam E_CFGRX = 4'd5;
  localparam E_HOOK = 4'd6;
  localparam E_BLIND = 4'd7;
  localparam E_TONE = 4'd8;
  localparam E_TONEW = 4'd9;
  localparam E_GAP = 4'd10;
  localparam E_GAPW = 4'd11;
  localparam E_CARR = 4'd12;
  localparam E_HANG = 4'd13;
  localparam E_DELAY = 4'd14;
  // parser states
  localparam P_IDLE = 3'd0;
  localparam P_A = 3'd1;
  localparam P_LINE = 3'd2;
  localparam P_AT = 3'd3;
  localparam P_ATR = 3'd4;
  localparam P_ARG = 3'd5;
  // full-width values first, then cut on purpose to the counter widths
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  localparam [31:0] PWR_RATIO = `MAE_PWR_WAIT_MS / `MAE_TICK_MS;
  localparam [18:0] TICK_MAX = TICK_LAST[18:0];
  localparam [15:0] PWR_TICKS = PWR_RATIO[15:0];

  reg [3:0] e_st; // exec state
  reg [2:0] p_st; // parser state
  reg [7:0] cur_cmd; // pending command letter
  reg [15:0] num; // decimal accumulator
  reg [7:0] idx; // index before '='
  reg [3:0] dial_buf [0:15]; // dial digit codes
  reg [4:0] dcount; // digits stored
  reg [4:0] dptr; // digit being sent
  reg [7:0] std_sel; // communication standard
  reg [7:0] dial_mode; // calling characteristic
  reg [7:0] s_wait; // blind dial wait, seconds
  reg [7:0] s_tout; // connect timeout, seconds
  reg [7:0] s_tone; // tone length, 10 ms units
  reg [7:0] s_equ; // equaliser setting
  reg [15:0] s_txs; // transmitter setup word
  reg [15:0] s_rxs; // receiver setup word
  reg [15:0] gc; // last general control word
  reg [15:0] txm; // last tx mode word
  reg [18:0] pre; // 10 ms prescaler
  reg [15:0] wcnt; // ticks left to wait
  reg cd_s1, cd_s2; // carrier synchroniser
  wire tick;
  wire busy;
  wire [7:0] ch;
  wire is_digit, is_letter, is_term;
  wire wb_req, char_wr, launch, accept;
  wire [15:0] num_x10;
  wire [3:0] dig_val;
  wire [15:0] gc_call;
  wire [15:0] tone_word;

  assign off_hook = gc[`MAE_GC_HOOK_BIT];
  assign busy = (e_st != E_IDLE);
  assign tick = (pre == TICK_MAX);

  // ==================================================
  // character classification
  // fold lower case onto upper case
  assign ch = (wb_dat_i[7:0] >= 8'h61 && wb_dat_i[7:0] <= 8'h7a) ?
              (wb_dat_i[7:0] - 8'h20) : wb_dat_i[7:0];
  assign is_digit = (ch >= `MAE_CH_0) && (ch <= `MAE_CH_9);
  assign is_letter = (ch >= `MAE_CH_A) && (ch <= `MAE_CH_Z);
  assign is_term = is_letter || (ch == `MAE_CH_AT) || (ch == `MAE_CH_CR);
  assign dig_val = ch[3:0];
  assign num_x10 = {num[12:0], 3'b000} + {num[14:0], 1'b0};

  // ==================================================
  // wishbone handshake
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign char_wr = wb_req && wb_we_i && wb_sel_i[0] &&
                   (wb_adr_i[4:2] == `MAE_OFS_CHAR);
  // a terminator closes the pending command first, then is retried
  assign launch = char_wr && !busy && (p_st == P_ARG) && is_term;
  assign accept = char_wr && !busy && !launch;

  // ack waits for the parser on char writes, else next cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req && (!char_wr || accept);
    end
  end

  // registered read data
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i[4:2])
        `MAE_OFS_STATUS: wb_dat_o <= {23'h000000, off_hook, 2'b00,
                                      result_code, 3'b000, busy};
        `MAE_OFS_GC: wb_dat_o <= {16'h0000, gc};
        `MAE_OFS_TX: wb_dat_o <= {16'h0000, txm};
        `MAE_OFS_SCFG_A: wb_dat_o <= {dial_mode, s_tone, s_tout, s_wait};
        `MAE_OFS_SCFG_B: wb_dat_o <= {std_sel, s_equ, s_txs};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ==================================================
  // line parser
  // one char per accepted write; commands run in arrival order
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      p_st <= P_IDLE;
      cur_cmd <= 8'h00;
      num <= 16'h0000;
      idx <= 8'h00;
      dcount <= 5'd0;
    end else if (launch) begin
      p_st <= P_LINE; // command handed to exec
    end else if (accept) begin
      case (p_st)
        P_IDLE: begin
          if (ch == `MAE_CH_A) p_st <= P_A;
        end
        P_A: begin
          p_st <= (ch == `MAE_CH_T) ? P_LINE : P_IDLE;
        end
        P_LINE: begin
          if (ch == `MAE_CH_CR) begin
            p_st <= P_IDLE;
          end else if (ch == `MAE_CH_AT) begin
            p_st <= P_AT;
          end else if (is_letter) begin
            cur_cmd <= ch;
            num <= 16'h0000;
            idx <= 8'h00;
            dcount <= 5'd0;
            p_st <= P_ARG;
          end
        end
        P_AT: begin
          if (ch == `MAE_CH_R) begin
            p_st <= P_ATR;
          end else if (ch == `MAE_CH_F) begin
            cur_cmd <= `MAE_CH_F;
            num <= 16'h0000;
            p_st <= P_ARG;
          end else begin
            p_st <= (ch == `MAE_CH_CR) ? P_IDLE : P_LINE;
          end
        end
        P_ATR: begin
          if (ch == `MAE_CH_E) begin
            cur_cmd <= `MAE_CH_W;
            num <= 16'h0000;
            idx <= 8'h00;
            p_st <= P_ARG;
          end else begin
            p_st <= (ch == `MAE_CH_CR) ? P_IDLE : P_LINE;
          end
        end
        P_ARG: begin
          // arguments; terminators never reach here
          if (cur_cmd == `MAE_CH_D) begin
            if ((is_digit || ch == `MAE_CH_STAR || ch == `MAE_CH_HASH) &&
                dcount != 5'd16) begin
              dcount <= dcount + 5'd1;
            end
          end else if (is_digit) begin
            num <= num_x10 + {12'h000, dig_val};
          end else if (ch == `MAE_CH_EQ) begin
            idx <= num[7:0];
            num <= 16'h0000;
          end
        end
        default: p_st <= P_IDLE;
      endcase
    end
  end

  // dial digit store, 0 -> 1010, * -> 1011, # -> 1100
  always @(posedge clk) begin
    if (accept && p_st == P_ARG && cur_cmd == `MAE_CH_D &&
        dcount != 5'd16) begin
      if (ch == `MAE_CH_STAR) dial_buf[dcount[3:0]] <= 4'hb;
      else if (ch == `MAE_CH_HASH) dial_buf[dcount[3:0]] <= 4'hc;
      else if (dig_val == 4'h0) dial_buf[dcount[3:0]] <= 4'ha;
      else if (is_digit) dial_buf[dcount[3:0]] <= dig_val;
    end
  end

  // ==================================================
  // timing and carrier input
  // carrier pin synchroniser
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cd_s1 <= 1'b0;
      cd_s2 <= 1'b0;
    end else begin
      cd_s1 <= carrier_detect;
      cd_s2 <= cd_s1;
    end
  end

  // prescaler restarts whenever a wait is loaded, except the carrier timeout
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= 19'd0;
    end else if (modem_wr || launch || tick) begin
      pre <= 19'd0;
    end else begin
      pre <= pre + 19'd1;
    end
  end

  // general control for a call: crystal, powered, off-hook, equaliser
  assign gc_call = `MAE_GC_NORM_WORD | (16'h0001 << `MAE_GC_HOOK_BIT) |
                   ({15'h0000, s_equ[0]} << `MAE_GC_EQU_BIT);
  // dtmf mode, 0 dB, unused bits zero, digit code in low field
  assign tone_word = {`MAE_TX_MODE_DTMF, `MAE_TX_LVL_0DB,
                      `MAE_TX_UNUSED, `MAE_TX_DIGIT_ON,
                      dial_buf[dptr[3:0]]};

  // ==================================================
  // command execution and modem chip writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      e_st <= E_PWR1;
      modem_wr <= 1'b0;
      modem_addr <= 8'h00;
      modem_wdata <= 16'h0000;
      gc <= 16'h0000;
      txm <= 16'h0000;
      wcnt <= 16'h0000;
      dptr <= 5'd0;
      result_code <= `MAE_RES_NONE;
      std_sel <= `MAE_STD_V22BIS;
      dial_mode <= `MAE_X_BLIND;
      s_wait <= `MAE_S6_RST;
      s_tout <= `MAE_S7_RST;
      s_tone <= `MAE_S11_RST;
      s_equ <= `MAE_S24_RST;
      s_txs <= `MAE_S25_RST;
      s_rxs <= `MAE_S26_RST;
    end else begin
      modem_wr <= 1'b0;
      case (e_st)
        E_PWR1: begin
          // chip reset request with power up
          modem_wr <= 1'b1;
          modem_addr <= `MAE_MREG_GC;
          modem_wdata <= `MAE_GC_RESET_WORD;
          gc <= `MAE_GC_RESET_WORD;
          wcnt <= PWR_TICKS;
          e_st <= E_PWRW;
        end
        E_PWRW: begin
          if (tick) wcnt <= wcnt - 16'd1;
          if (wcnt == 16'd0) e_st <= E_PWR2;
        end
        E_PWR2: begin
          modem_wr <= 1'b1;
          modem_addr <= `MAE_MREG_GC;
          modem_wdata <= `MAE_GC_NORM_WORD;
          gc <= `MAE_GC_NORM_WORD;
          e_st <= E_IDLE;
        end
        E_IDLE: begin
          if (launch) begin
            case (cur_cmd)
              `MAE_CH_B: std_sel <= num[7:0];
              `MAE_CH_X: dial_mode <= num[7:0];
              `MAE_CH_H: e_st <= E_HOOK;
              `MAE_CH_S: begin
                case (idx)
                  `MAE_SIDX_WAIT: s_wait <= num[7:0];
                  `MAE_SIDX_TIMEOUT: s_tout <= num[7:0];
                  `MAE_SIDX_TONE: s_tone <= num[7:0];
                  `MAE_SIDX_EQU: s_equ <= num[7:0];
                  `MAE_SIDX_TXS: s_txs <= num;
                  `MAE_SIDX_RXS: s_rxs <= num;
                  default: s_wait <= s_wait;
                endcase
              end
              `MAE_CH_W: begin
                // raw word to E0 hex plus index
                modem_wr <= 1'b1;
                modem_addr <= `MAE_MREG_BASE + idx;
                modem_wdata <= num;
                if (idx == 8'd0) gc <= num;
                if (idx == 8'd1) txm <= num;
              end
              `MAE_CH_F: begin
                if (num == `MAE_DLY_F2) begin
                  wcnt <= PWR_TICKS;
                  e_st <= E_DELAY;
                end
              end
              `MAE_CH_D: begin
                // configure, then go off-hook
                result_code <= `MAE_RES_NONE;
                dptr <= 5'd0;
                modem_wr <= 1'b1;
                modem_addr <= `MAE_MREG_TX;
                modem_wdata <= s_txs;
                txm <= s_txs;
                e_st <= E_CFGRX;
              end
              default: e_st <= E_IDLE;
            endcase
          end
        end
        E_CFGRX: begin
          modem_wr <= 1'b1;
          modem_addr <= `MAE_MREG_RX;
          modem_wdata <= s_rxs;
          e_st <= E_CFGTX;
        end
        E_CFGTX: begin
          // off-hook with equaliser choice, then blind wait
          modem_wr <= 1'b1;
          modem_addr <= `MAE_MREG_GC;
          modem_wdata <= gc_call;
          gc <= gc_call;
          wcnt <= s_wait * `MAE_TICKS_PER_S;
          e_st <= E_BLIND;
        end
        E_HOOK: begin
          modem_wr <= 1'b1;
          modem_addr <= `MAE_MREG_GC;
          modem_wdata <= (gc & ~(16'h0001 << `MAE_GC_HOOK_BIT)) |
                         ({15'h0000, num[0]} << `MAE_GC_HOOK_BIT);
          gc <= (gc & ~(16'h0001 << `MAE_GC_HOOK_BIT)) |
                ({15'h0000, num[0]} << `MAE_GC_HOOK_BIT);
          e_st <= E_IDLE;
        end
        E_BLIND: begin
          // no dial tone check, no busy check
          if (tick) wcnt <= wcnt - 16'd1;
          if (wcnt == 16'd0) e_st <= E_TONE;
        end
        E_TONE: begin
          if (dptr == dcount) begin
            wcnt <= s_tout * `MAE_TICKS_PER_S;
            e_st <= E_CARR;
          end else begin
            modem_wr <= 1'b1;
            modem_addr <= `MAE_MREG_TX;
            modem_wdata <= tone_word;
            txm <= tone_word;
            wcnt <= {8'h00, s_tone};
            e_st <= E_TONEW;
          end
        end
        E_TONEW: begin
          if (tick) wcnt <= wcnt - 16'd1;
          if (wcnt == 16'd0) e_st <= E_GAP;
        end
        E_GAP: begin
          modem_wr <= 1'b1;
          modem_addr <= `MAE_MREG_TX;
          modem_wdata <= `MAE_TX_NO_TONE;
          txm <= `MAE_TX_NO_TONE;
          wcnt <= {8'h00, s_tone};
          dptr <= dptr + 5'd1;
          e_st <= E_GAPW;
        end
        E_GAPW: begin
          if (tick) wcnt <= wcnt - 16'd1;
          if (wcnt == 16'd0) e_st <= E_TONE;
        end
        E_CARR: begin
          if (cd_s2) begin
            result_code <= `MAE_RES_CONNECT;
            e_st <= E_IDLE;
          end else if (wcnt == 16'd0) begin
            result_code <= `MAE_RES_NOCARR;
            e_st <= E_HANG;
          end else if (tick) begin
            wcnt <= wcnt - 16'd1;
          end
        end
        E_HANG: begin
          modem_wr <= 1'b1;
          modem_addr <= `MAE_MREG_GC;
          modem_wdata <= `MAE_GC_NORM_WORD;
          gc <= `MAE_GC_NORM_WORD;
          e_st <= E_IDLE;
        end
        E_DELAY: begin
          if (tick) wcnt <= wcnt - 16'd1;
          if (wcnt == 16'd0) e_st <= E_IDLE;
        end
        default: e_st <= E_IDLE;
      endcase
    end
  end

endmodule // mae_at_ctrl

//--- tb/mae_at_ctrl_asserts.sv
`timescale 1ns/1ps
// ==================================================
// port checks for the command controller
module mae_at_ctrl_asserts #(
  parameter TICK_CYCLES = 20
) (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire carrier_detect,
  input wire modem_wr,
  input wire [7:0] modem_addr,
  input wire [15:0] modem_wdata,
  input wire off_hook,
  input wire [1:0] result_code
);
  localparam int PWR = 10 * TICK_CYCLES; // power-up wait in cycles
  int gap; // cycles since the last modem write
  logic [1:0] nwr; // modem writes since reset, saturating
  logic [5:0] car_hist; // recent carrier samples
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==================================================
  // helper history
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gap <= 0;
      nwr <= 2'd0;
      car_hist <= 6'h00;
    end else begin
      car_hist <= {car_hist[4:0], carrier_detect};
      gap <= modem_wr ? 0 : gap + 1;
      if (modem_wr && nwr != 2'd3) begin
        nwr <= nwr + 2'd1;
      end
    end
  end
  // ==================================================
  // named steps
  sequence s_gc_write;
    modem_wr && modem_addr == 8'he0;
  endsequence
  sequence s_reset_word;
    modem_wr && modem_addr == 8'he0 && modem_wdata == 16'h1180;
  endsequence
  sequence s_onhook;
    modem_wr && modem_addr == 8'he0 && modem_wdata == 16'h1100;
  endsequence
  // ==================================================
  // assertions
  AST_BOOT_RESET_WORD: assert property (
    $fell(rst) |-> ##[0:3] s_reset_word) else $error("no reset word");
  AST_BOOT_POWER_WORD: assert property (
    (modem_wr && nwr == 2'd1) |-> gap >= PWR - 3 && gap <= PWR + 3
    && modem_wdata == 16'h1100 && modem_addr == 8'he0)
    else $error("power word wrong");
  AST_GC_FIXED_BITS: assert property (
    s_gc_write |-> modem_wdata[12] && !modem_wdata[11] && !modem_wdata[6])
    else $error("control fixed bits");
  AST_HOOK_FOLLOWS_GC: assert property (
    s_gc_write |=> off_hook == $past(modem_wdata[9]))
    else $error("hook not from control word");
  AST_HOOK_ONLY_ON_GC: assert property (
    $changed(off_hook) |-> (modem_wr && modem_addr == 8'he0)
    || $past(modem_wr && modem_addr == 8'he0))
    else $error("hook moved alone");
  AST_MREG_BASE: assert property (
    modem_wr |-> modem_addr[7:4] == 4'he) else $error("modem addr off");
  AST_RESULT_LEGAL: assert property (
    result_code != 2'd3) else $error("bad result");
  AST_CONNECT_CARRIER: assert property (
    $rose(result_code == 2'd1) |-> |car_hist)
    else $error("connect with no carrier");
  AST_NOCARR_HANGUP: assert property (
    $rose(result_code == 2'd2) |-> ##[0:8] s_onhook)
    else $error("no hang up");
  AST_ACK_ONE_CYCLE: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_HAS_REQ: assert property (
    wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("stray ack");
  AST_READ_NEXT: assert property (
    (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> wb_ack_o)
    else $error("read ack late");
endmodule // mae_at_ctrl_asserts

bind mae_at_ctrl mae_at_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .carrier_detect(carrier_detect), .modem_wr(modem_wr),
  .modem_addr(modem_addr), .modem_wdata(modem_wdata),
  .off_hook(off_hook), .result_code(result_code));

//--- tb/mae_modem_model.sv
`timescale 1ns/1ps
// ==================================================
// modem chip stand-in: logs writes, far end gives carrier
module mae_modem_model (
  input wire clk,
  input wire modem_wr,
  input wire [7:0] modem_addr,
  input wire [15:0] modem_wdata,
  input wire off_hook,
  input wire carrier_on,
  output logic carrier_detect
);
  logic [7:0] log_a [0:63]; // register address per write
  logic [15:0] log_d [0:63]; // word per write
  int log_t [0:63]; // cycle stamp per write
  int n = 0; // writes seen
  int cyc = 0; // free cycle count
  initial carrier_detect = 1'b0;
  // record the first 64 strobed writes with their cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (modem_wr && n < 64) begin
      log_a[n] <= modem_addr;
      log_d[n] <= modem_wdata;
      log_t[n] <= cyc;
      n <= n + 1;
    end
  end
  // far modem only answers a line that is off-hook
  always @(posedge clk) begin
    carrier_detect <= carrier_on && off_hook;
  end
endmodule // mae_modem_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
// ==================================================
// bench for the command controller
module tb_top;
  localparam int TICK = 20; // short 10 ms tick
  logic clk, rst, cyc, stb, we, car_on;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] dat_w;
  wire [31:0] dat_r;
  wire ack, mwr, hook, car;
  wire [7:0] maddr;
  wire [15:0] mdata;
  wire [1:0] res;
  int err_total, samples_checked, rd, wdog;

  mae_at_ctrl #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
    .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .carrier_detect(car), .modem_wr(mwr), .modem_addr(maddr),
    .modem_wdata(mdata), .off_hook(hook), .result_code(res));
  mae_modem_model modem (.clk(clk), .modem_wr(mwr), .modem_addr(maddr),
    .modem_wdata(mdata), .off_hook(hook), .carrier_on(car_on),
    .carrier_detect(car));
  // ==================================================
  // shared tasks
  task check(input [31:0] exp, input [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // one classic bus cycle, held until ack
  task wb(input [7:0] a, input w, input [31:0] d, output [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20000);
    check(32'h1, {31'h0, ack}); // a bus wait that never ends is a miss
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    check(e, q);
  endtask
  // a command line, closed by carriage return
  task send(input string s);
    logic [31:0] q;
    for (int i = 0; i < s.len(); i++) wb(8'h00, 1'b1, {24'h0, s[i]}, q);
    wb(8'h00, 1'b1, 32'h0000000d, q);
  endtask
  // next logged modem write must match
  task exp_wr(input [7:0] a, input [15:0] d);
    int n;
    n = 0;
    while (modem.n <= rd && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check({8'h0, a, d}, {8'h0, modem.log_a[rd], modem.log_d[rd]});
    rd++;
  endtask
  // spacing of the last two modem writes
  task gap_chk(input int lo, input int hi);
    int d;
    d = modem.log_t[rd - 1] - modem.log_t[rd - 2];
    check(32'h1, {31'h0, d >= lo && d <= hi});
  endtask
  // ==================================================
  // scenarios
  task t_boot();
    exp_wr(8'he0, 16'h1180);
    rd_chk(8'h10, 32'h010a3202);
    rd_chk(8'h14, 32'h00001e00);
    rd_chk(8'h18, 32'h00000000);
    exp_wr(8'he0, 16'h1100);
    gap_chk(10 * TICK, 10 * TICK + 3);
    $display("boot test done");
  endtask
  task t_eval();
    send("AT@RE0=4480@F2@RE0=4352");
    exp_wr(8'he0, 16'h1180);
    exp_wr(8'he0, 16'h1100);
    gap_chk(10 * TICK, 20 * TICK);
    send("ATH1@RE1=7685");
    exp_wr(8'he0, 16'h1300);
    exp_wr(8'he1, 16'h1e05);
    check(32'h1, {31'h0, hook});
    send("at@re1=4101@RE1=7690");
    exp_wr(8'he1, 16'h1005);
    exp_wr(8'he1, 16'h1e0a);
    send("ATH0");
    exp_wr(8'he0, 16'h1100);
    $display("eval test done");
  endtask
  task t_dial_connect();
    car_on <= 1'b1;
    send("ATB0X1S6=1S11=15S7=1S25=7685S26=7681S24=1");
    rd_chk(8'h10, 32'h010f0101);
    rd_chk(8'h14, 32'h00011e05);
    send("ATD0#");
    exp_wr(8'he1, 16'h1e05);
    exp_wr(8'he2, 16'h1e01);
    exp_wr(8'he0, 16'h1700);
    exp_wr(8'he1, 16'h1e1a);
    gap_chk(100 * TICK, 101 * TICK);
    exp_wr(8'he1, 16'h1e00);
    gap_chk(15 * TICK, 16 * TICK);
    exp_wr(8'he1, 16'h1e1c);
    exp_wr(8'he1, 16'h1e00);
    check(32'h1, {30'h0, res});
    rd_chk(8'h04, 32'h00000110);
    send("ATH0");
    exp_wr(8'he0, 16'h1500);
    $display("connect test done");
  endtask
  task t_dial_silent();
    car_on <= 1'b0;
    send("ATS24=0D5");
    exp_wr(8'he1, 16'h1e05);
    exp_wr(8'he2, 16'h1e01);
    exp_wr(8'he0, 16'h1300);
    exp_wr(8'he1, 16'h1e15);
    exp_wr(8'he1, 16'h1e00);
    exp_wr(8'he0, 16'h1100);
    gap_chk(115 * TICK, 117 * TICK);
    check(32'h2, {30'h0, res});
    rd_chk(8'h04, 32'h00000020);
    $display("no carrier test done");
  endtask
  // ==================================================
  // verdict
  task complete_run();
    $display("checked=%0d bad=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    wdog <= wdog + 1;
    if (wdog == 60000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    dat_w = 32'h0;
    car_on = 1'b0;
    err_total = 0;
    samples_checked = 0;
    rd = 0;
    wdog = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_boot();
    t_eval();
    t_dial_connect();
    t_dial_silent();
    complete_run();
  end
endmodule // tb_top
